// ---- lesa_consts.vh ----
// Constants of the link event status block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef LESA_CONSTS_VH
`define LESA_CONSTS_VH

// Register byte addresses
`define LESA_ADDR_STATUS     12'h008
`define LESA_ADDR_ENABLE     12'h00c
`define LESA_ADDR_TMR_CTRL   12'h020
`define LESA_ADDR_TMR_LOAD   12'h024
`define LESA_ADDR_TMR_COUNT  12'h028
`define LESA_ADDR_NODE_CTRL  12'h02c

// Status / enable bit positions
`define LESA_BIT_AUTH_DONE   21
`define LESA_BIT_TIMER       20
`define LESA_BIT_CMD_RESET   18
`define LESA_BIT_FAIR_GAP    17
`define LESA_BIT_ARB_GAP     16
`define LESA_BIT_PHY_EVENT   15
`define LESA_BIT_BUS_RESET   13

// Bits that exist; all others read as zero
`define LESA_EVENT_MASK      32'h0037a000

// Timer control fields
`define LESA_TMR_RUN_BIT     0
`define LESA_TMR_REPEAT_BIT  1
`define LESA_TMR_WIDTH       24

// Node control field
`define LESA_NODE_VALID_BIT  0

// Reset values
`define LESA_RST_STATUS      32'h00000000
`define LESA_RST_ENABLE      32'h00000000
`define LESA_RST_TMR_LOAD    24'h000000
`define LESA_RST_TMR_CTRL    2'h0

// Timing: timer tick period and clock rate
`define LESA_TICK_NS         1000
`define LESA_CLK_MHZ         40
`define LESA_TICK_CYCLES     ((`LESA_TICK_NS * `LESA_CLK_MHZ) / 1000)
`define LESA_PRESCALE_WIDTH  6

`endif

// ---- lesa_timer.v ----
// General-purpose down-counting timer with one-shot or repeating expiry.
// Assumes one clock; load and control come from the register file.
`timescale 1ns/1ps
`include "lesa_consts.vh"

module lesa_timer (
  input  wire                          pclk,
  input  wire                          presetn,
  input  wire                          load_we,
  input  wire [`LESA_TMR_WIDTH-1:0]    load_val,
  input  wire                          run,
  input  wire                          repeat_sel,
  output reg                           expire_pulse,
  output reg  [`LESA_TMR_WIDTH-1:0]    count_reg
);

  reg  [`LESA_PRESCALE_WIDTH-1:0] presc_reg;
  reg  [`LESA_TMR_WIDTH-1:0]      reload_reg;
  wire                            tick;

  localparam integer                    PRESC_LAST_INT = `LESA_TICK_CYCLES - 1;
  localparam [`LESA_PRESCALE_WIDTH-1:0] PRESC_LAST     =
    PRESC_LAST_INT[`LESA_PRESCALE_WIDTH-1:0];

  assign tick = (presc_reg == PRESC_LAST);

  // Microsecond tick divider, cleared to zero while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= {`LESA_PRESCALE_WIDTH{1'b0}};
    end else if (!run || tick) begin
      presc_reg <= {`LESA_PRESCALE_WIDTH{1'b0}};
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg    <= `LESA_RST_TMR_LOAD;
      reload_reg   <= `LESA_RST_TMR_LOAD;
      expire_pulse <= 1'b0;
    end else begin
      expire_pulse <= 1'b0;
      if (load_we) begin
        reload_reg <= load_val;
        count_reg  <= load_val;
      end else if (run && tick && count_reg != {`LESA_TMR_WIDTH{1'b0}}) begin
        if (count_reg == {{(`LESA_TMR_WIDTH-1){1'b0}}, 1'b1}) begin
          expire_pulse <= 1'b1;                          // [RULE_05]
          // Repeat reloads for another period; one-shot stays at zero
          count_reg    <= repeat_sel ? reload_reg : {`LESA_TMR_WIDTH{1'b0}}; // [RULE_06]
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule

// ---- lesa_event_status.v ----
// Link event status / acknowledge block with enable mask and interrupt.
// Assumes an APB master on pclk and event inputs as one-cycle pulses.
//
// Notes on behaviour
// RULE_01: 32-bit status plus same-layout enable register.
// RULE_02: Writing one clears a set bit.
// RULE_03: Writes never set status bits.
// RULE_04: Bit 21 set on accelerator done.
// RULE_05: Bit 20 set at timer zero, sticky.
// RULE_06: Timer fires once, or each reload if repeating.
// RULE_07: Bit 18 set on reset-start write received.
// RULE_08: Bit 17 set on subaction gap idle.
// RULE_09: Bit 16 set on arbitration reset gap.
// RULE_10: Bit 15 set on PHY interrupt report.
// RULE_11: Bit 13 on bus reset; clears node valid, flushes.
// RULE_12: Interrupt high while any enabled status bit set.
`timescale 1ns/1ps
`include "lesa_consts.vh"

module lesa_event_status (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        auth_accel_done,
  input  wire        command_reset_seen,
  input  wire        subaction_gap_seen,
  input  wire        arb_reset_gap_seen,
  input  wire        phy_event_flag,
  input  wire        bus_reset_started,
  input  wire        node_id_set,
  output reg         node_id_valid,
  output reg         async_flush,
  output reg         irq
);

  reg  [31:0]                  status_reg;
  reg  [31:0]                  status_next;
  reg  [31:0]                  enable_reg;
  reg  [1:0]                   tmr_ctrl_reg;
  reg  [`LESA_TMR_WIDTH-1:0]   tmr_load_reg;
  reg  [31:0]                  set_vec;
  reg  [31:0]                  clr_vec;
  reg  [31:0]                  rd_mux;
  reg                          rd_hit;
  reg                          node_valid_next;
  wire                         setup_phase;
  wire                         access_done;
  wire                         wr_done;
  wire                         tmr_expire;
  wire [`LESA_TMR_WIDTH-1:0]   tmr_count;

  // APB phases; the access completes at the edge where pready is high
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite && !pslverr;

  lesa_timer u_timer (
    .pclk         (pclk),
    .presetn      (presetn),
    .load_we      (wr_done && paddr == `LESA_ADDR_TMR_LOAD),
    .load_val     (pwdata[`LESA_TMR_WIDTH-1:0]),
    .run          (tmr_ctrl_reg[`LESA_TMR_RUN_BIT]),
    .repeat_sel   (tmr_ctrl_reg[`LESA_TMR_REPEAT_BIT]),
    .expire_pulse (tmr_expire),
    .count_reg    (tmr_count)
  );

  // Hardware events entering the status register
  always @* begin
    set_vec = 32'h00000000;
    set_vec[`LESA_BIT_AUTH_DONE] = auth_accel_done;     // [RULE_04]
    set_vec[`LESA_BIT_TIMER]     = tmr_expire;          // [RULE_05]
    set_vec[`LESA_BIT_CMD_RESET] = command_reset_seen;  // [RULE_07]
    set_vec[`LESA_BIT_FAIR_GAP]  = subaction_gap_seen;  // [RULE_08]
    set_vec[`LESA_BIT_ARB_GAP]   = arb_reset_gap_seen;  // [RULE_09]
    set_vec[`LESA_BIT_PHY_EVENT] = phy_event_flag;      // [RULE_10]
    set_vec[`LESA_BIT_BUS_RESET] = bus_reset_started;   // [RULE_11]
  end

  // Write-one-to-clear; an event in the same cycle wins over the clear
  always @* begin
    clr_vec = 32'h00000000;
    if (wr_done && paddr == `LESA_ADDR_STATUS) begin
      clr_vec = pwdata & status_reg;                    // [RULE_02]
    end
    // Only hardware events may set a bit
    status_next = ((status_reg & ~clr_vec) | set_vec) & `LESA_EVENT_MASK; // [RULE_03]
  end

  // Node ID valid: cleared when a bus reset starts, reset wins over set
  always @* begin
    node_valid_next = node_id_valid;
    if (node_id_set) begin
      node_valid_next = 1'b1;
    end
    if (wr_done && paddr == `LESA_ADDR_NODE_CTRL) begin
      node_valid_next = pwdata[`LESA_NODE_VALID_BIT];
    end
    if (bus_reset_started) begin
      node_valid_next = 1'b0;                           // [RULE_11]
    end
  end

  // Read multiplexer and address decode
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `LESA_ADDR_STATUS: begin
        rd_mux = status_reg;                            // [RULE_01]
      end
      `LESA_ADDR_ENABLE: begin
        rd_mux = enable_reg;                            // [RULE_01]
      end
      `LESA_ADDR_TMR_CTRL: begin
        rd_mux[1:0] = tmr_ctrl_reg;
      end
      `LESA_ADDR_TMR_LOAD: begin
        rd_mux[`LESA_TMR_WIDTH-1:0] = tmr_load_reg;
      end
      `LESA_ADDR_TMR_COUNT: begin
        rd_mux[`LESA_TMR_WIDTH-1:0] = tmr_count;
      end
      `LESA_ADDR_NODE_CTRL: begin
        rd_mux[`LESA_NODE_VALID_BIT] = node_id_valid;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end
  end

  // APB answer: one wait-free access phase after every setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= !rd_hit;
        prdata  <= (pwrite || !rd_hit) ? 32'h00000000 : rd_mux;
      end else if (access_done) begin
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

  // Software-written registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg   <= `LESA_RST_ENABLE;
      tmr_ctrl_reg <= `LESA_RST_TMR_CTRL;
      tmr_load_reg <= `LESA_RST_TMR_LOAD;
    end else if (wr_done) begin
      // Read-back copy of the reload value held in the timer
      if (paddr == `LESA_ADDR_TMR_LOAD) begin
        tmr_load_reg <= pwdata[`LESA_TMR_WIDTH-1:0];
      end
      if (paddr == `LESA_ADDR_ENABLE) begin
        enable_reg <= pwdata & `LESA_EVENT_MASK;        // [RULE_01]
      end
      if (paddr == `LESA_ADDR_TMR_CTRL) begin
        tmr_ctrl_reg <= pwdata[1:0];                    // [RULE_06]
      end
    end
  end

  // Status, node state, flush strobe and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg    <= `LESA_RST_STATUS;
      node_id_valid <= 1'b0;
      async_flush   <= 1'b0;
      irq           <= 1'b0;
    end else begin
      status_reg    <= status_next;
      node_id_valid <= node_valid_next;
      async_flush   <= bus_reset_started;               // [RULE_11]
      irq           <= |(status_next & enable_reg);     // [RULE_12]
    end
  end

endmodule

// ---- lesa_event_checker.sv ----
// Checker for bus, flush, node-valid and interrupt timing.
// Assumes binding to lesa_event_status ports.
`timescale 1ns/1ps
`include "lesa_consts.vh"
module lesa_event_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        bus_reset_started,
  input wire        node_id_set,
  input wire        node_id_valid,
  input wire        async_flush,
  input wire        irq
);
  wire wr    = psel && pwrite;
  wire setup = psel && !penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    setup;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  a_err_unaligned: assert property (s_setup ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_status_bits: assert property (pready && paddr == `LESA_ADDR_STATUS |->
    (prdata & ~`LESA_EVENT_MASK) == 32'h0) else $error("status reserved bit set");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_flush_follow: assert property (bus_reset_started |=> async_flush)
    else $error("no flush after bus reset");
  a_flush_cause: assert property (async_flush |-> $past(bus_reset_started))
    else $error("flush without bus reset");
  a_valid_clear: assert property (bus_reset_started |=> !node_id_valid)
    else $error("node valid kept over bus reset");
  a_node_set: assert property (node_id_set && !bus_reset_started && !wr |=> node_id_valid)
    else $error("node valid not set");
  a_irq_hold: assert property (irq && !wr |=> irq)
    else $error("irq dropped without write");
endmodule

// ---- tb.sv ----
// Self-checking bench for the link event status block.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
`include "lesa_consts.vh"
module tb;
  localparam logic [11:0] a_st = `LESA_ADDR_STATUS;
  localparam logic [11:0] a_en = `LESA_ADDR_ENABLE;
  logic        pclk, presetn, psel, penable, pwrite, node_id_set, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [5:0]  ev;
  wire  [31:0] prdata;
  wire         pready, pslverr, node_id_valid, async_flush, irq;
  int          error_cnt, check_count, cyc;
  int          bitpos [6] = '{21, 18, 17, 16, 15, 13};
  lesa_event_status lesa_event_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auth_accel_done(ev[0]), .command_reset_seen(ev[1]),
    .subaction_gap_seen(ev[2]), .arb_reset_gap_seen(ev[3]), .phy_event_flag(ev[4]),
    .bus_reset_started(ev[5]), .node_id_set(node_id_set), .node_id_valid(node_id_valid),
    .async_flush(async_flush), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    // Answer stands until the completing edge
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 6'h00;
    #1;
  endtask
  task wait_irq;
    for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
  endtask
  task t_regs;
    rd_chk("status", a_st, `LESA_RST_STATUS);
    rd_chk("enable", a_en, `LESA_RST_ENABLE);
    apb(1'b1, a_st, 32'hffffffff);
    rd_chk("status", a_st, 32'h0);
    apb(1'b1, a_en, 32'hffffffff);
    rd_chk("enable", a_en, `LESA_EVENT_MASK);
    apb(1'b0, 12'h006, 32'h0);
    check("slverr", err, 1'b1);
    $display("test regs done");
  endtask
  task t_events;
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      check("flush", async_flush, k == 5);
      check("irq", irq, 1'b1);
      rd_chk("status", a_st, 32'h1 << bitpos[k]);
      apb(1'b1, a_st, 32'h1 << bitpos[k]);
      rd_chk("status", a_st, 32'h0);
      check("irq", irq, 1'b0);
    end
    $display("test events done");
  endtask
  task t_node;
    @(posedge pclk);
    node_id_set <= 1'b1;
    @(posedge pclk);
    node_id_set <= 1'b0;
    #1;
    check("valid", node_id_valid, 1'b1);
    pulse(5);
    check("valid", node_id_valid, 1'b0);
    apb(1'b1, a_st, 32'h1 << 13);
    apb(1'b1, a_en, 32'h1 << 20);
    pulse(2);
    check("irq", irq, 1'b0);
    rd_chk("status", a_st, 32'h1 << 17);
    apb(1'b1, a_st, 32'h1 << 17);
    $display("test node and mask done");
  endtask
  task t_timer;
    apb(1'b1, `LESA_ADDR_TMR_LOAD, 32'h2);
    apb(1'b1, `LESA_ADDR_TMR_CTRL, 32'h1);
    wait_irq;
    check("irq", irq, 1'b1);
    repeat (10) @(posedge pclk);
    rd_chk("status", a_st, 32'h1 << 20);
    apb(1'b1, a_st, 32'h1 << 20);
    wait_irq;
    check("irq", irq, 1'b0);
    rd_chk("count", `LESA_ADDR_TMR_COUNT, 32'h0);
    apb(1'b1, `LESA_ADDR_TMR_LOAD, 32'h2);
    apb(1'b1, `LESA_ADDR_TMR_CTRL, 32'h3);
    repeat (2) begin
      wait_irq;
      check("irq", irq, 1'b1);
      apb(1'b1, a_st, 32'h1 << 20);
    end
    apb(1'b1, `LESA_ADDR_TMR_CTRL, 32'h0);
    $display("test timer done");
  endtask
  initial begin
    {psel, penable, pwrite, node_id_set} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 6'h00;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_events;
    t_node;
    t_timer;
    finish_test;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test;
    end
  end
endmodule
bind lesa_event_status lesa_event_checker lesa_event_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_reset_started(bus_reset_started),
  .node_id_set(node_id_set), .node_id_valid(node_id_valid), .async_flush(async_flush),
  .irq(irq));
